// [inc/rcc_pkg.sv]
// Constants for the reset cause controller: register map, field
// positions, reset values and bus answer codes.
// Assumes a 32-bit AXI4-Lite bus with one word per register.
package rcc_pkg;
	// Register map
	localparam int          RCC_AW          = 8;
	localparam logic [7:0]  RCC_STATUS_OFS  = 8'h00;
	// Field positions of the reset cause status word
	localparam int          RCC_B_POR       = 0;
	localparam int          RCC_B_BROWNOUT  = 1;
	localparam int          RCC_B_IDLE      = 2;
	localparam int          RCC_B_SLEEP     = 3;
	localparam int          RCC_B_WATCHDOG_TIMEOUT_FLAG      = 4;
	localparam int          RCC_B_WDT_EN    = 5;
	localparam int          RCC_B_INSTR     = 6;
	localparam int          RCC_B_EXTPIN    = 7;
	localparam int          RCC_B_MAIN_REG  = 8;
	localparam int          RCC_B_CFGMIS    = 9;
	localparam int          RCC_B_FLASH_REG = 11;
	localparam int          RCC_B_ILLEGAL   = 14;
	localparam int          RCC_B_TRAP      = 15;
	// Implemented bits; 13, 12 and 10 read as zero
	localparam logic [15:0] RCC_IMPL_MASK   = 16'hCBFF;
	// Value after power-on: brown-out and power-on flags set
	localparam logic [15:0] RCC_POR_VAL     = 16'h0003;
	// Watchdog configuration that forces the watchdog on
	localparam logic [1:0]  RCC_WDT_CFG_ON  = 2'h3;
	localparam logic [2:0]  RCC_OSC_RST     = 3'h0;
	// AXI answer codes
	localparam logic [1:0]  RCC_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RCC_RESP_SLVERR = 2'h2;
endpackage

// [logic/rcc_sync.sv]
// Three-stage synchroniser for asynchronous pin levels.
// The output changes only once stages two and three agree.
`timescale 1ns/10ps
module rcc_sync
	import rcc_pkg::*;
#(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;
	wire  [W-1:0] agree = ~(s2_r ^ s3_r);

	// Shift chain, then take each bit once stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q_r  <= RST_VAL;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r  <= (agree & s3_r) | (~agree & q_r);
		end
	end

	assign dout = q_r;
endmodule

// [logic/rcc_axil.sv]
// AXI4-Lite slave front end: takes write address and data in either
// order, hands one write strobe and one read strobe to the register
// file, and returns its answers. One write and one read at a time.
`timescale 1ns/10ps
module rcc_axil
	import rcc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [RCC_AW-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [RCC_AW-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   wr_en,
	output logic      [RCC_AW-1:0] wr_addr,
	output logic      [31:0]       wr_data,
	output logic      [3:0]        wr_strb,
	input  wire logic              wr_ok,
	output logic                   rd_en,
	output logic      [RCC_AW-1:0] rd_addr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_ok
);
	logic              aw_got_r;
	logic              w_got_r;
	logic [RCC_AW-1:0] aw_addr_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [1:0]        rresp_r;
	logic [31:0]       rdata_r;

	// Handshake decode
	assign awready = !aw_got_r && !bvalid_r;
	assign wready  = !w_got_r && !bvalid_r;
	assign arready = !rvalid_r;
	wire   aw_hs   = awvalid && awready;
	wire   w_hs    = wvalid && wready;
	assign wr_en   = aw_got_r && w_got_r && !bvalid_r;
	assign wr_addr = aw_addr_r;
	assign wr_data = w_data_r;
	assign wr_strb = w_strb_r;
	assign rd_en   = arvalid && arready;
	assign rd_addr = araddr;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = rdata_r;

	// Write channel: capture both halves, then answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= '0;
			w_strb_r  <= '0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RCC_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= awaddr;
			end
			if (w_hs) begin
				w_got_r  <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end
			if (wr_en) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= wr_ok ? RCC_RESP_OKAY : RCC_RESP_SLVERR;
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Read channel: data registered one cycle after address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			rresp_r  <= RCC_RESP_OKAY;
			rdata_r  <= '0;
		end else if (rd_en) begin
			rvalid_r <= 1'b1;
			rresp_r  <= rd_ok ? RCC_RESP_OKAY : RCC_RESP_SLVERR;
			rdata_r  <= rd_data;
		end else if (rvalid_r && rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule

// [logic/rcc_top.sv]
// Reset cause controller: merges every reset source into one master
// system reset, records causes in a status word, and drives the
// watchdog enable, regulator sleep controls and start-up oscillator.
// Assumes RSTN is the power-on reset, pins are asynchronous and the
// other event inputs come from logic on REF_CLK.
//
// How it works
// - all sources merge into one master reset
// - any active source asserts master reset
// - every reset kind sets its cause flag
// - power-on leaves only brown-out and power-on set
// - software sets or clears flags, no reset
// - every reset loads start-up oscillator selection
// - trap conflict sets bit 15
// - illegal opcode, mode or register sets bit 14
// - bit 11 keeps flash regulator on in sleep
// - bit 8 keeps main regulator on in sleep
// - master clear pin sets bit 7
// - reset instruction sets bit 6
// - bit 5 enables watchdog unless config forces
// - watchdog time-out sets bit 4
// - sleep sets bit 3, idle sets bit 2
// - brown-out sets bit 1, power-on bit 0
// - bits 13, 12 and 10 read zero
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module rcc_top
	import rcc_pkg::*;
(
	input  wire logic              REF_CLK,
	input  wire logic              RSTN,
	input  wire logic              MASTER_CLEAR_PIN_N,
	input  wire logic              BROWNOUT_DETECT,
	input  wire logic              INSTR_RESET_REQ,
	input  wire logic              WATCHDOG_TIMEOUT,
	input  wire logic              CONFIG_MISMATCH,
	input  wire logic              TRAP_CONFLICT,
	input  wire logic              ILLEGAL_OPCODE,
	input  wire logic              ILLEGAL_ADDR_MODE,
	input  wire logic              UNINIT_WREG_POINTER,
	input  wire logic              SLEEP_ENTERED,
	input  wire logic              IDLE_ENTERED,
	input  wire logic [1:0]        WATCHDOG_CONFIG_FIELD,
	input  wire logic [2:0]        STARTUP_OSCILLATOR_SELECT,
	output logic                   MASTER_SYSTEM_RESET,
	output logic [2:0]             NEW_OSCILLATOR_FIELD,
	output logic                   WATCHDOG_RUN,
	output logic                   FLASH_REGULATOR_SLEEP_ACTIVE,
	output logic                   MAIN_REGULATOR_SLEEP_ACTIVE,
	input  wire logic [RCC_AW-1:0] AWADDR,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	output logic [1:0]             BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	input  wire logic [RCC_AW-1:0] ARADDR,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY
);
	logic              rst_m_r;
	logic              rst_n;
	logic [1:0]        pins;
	logic              wr_en;
	logic [RCC_AW-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              rd_en;
	logic [RCC_AW-1:0] rd_addr;
	logic [15:0]       st_r;
	logic [15:0]       st_nxt;
	logic              sys_rst_r;
	logic [2:0]        osc_r;

	// Word-aligned decode of the status register
	function automatic logic rcc_hit(input logic [RCC_AW-1:0] a);
		return a[RCC_AW-1:2] == RCC_STATUS_OFS[RCC_AW-1:2];
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_m_r <= 1'b0;
			rst_n   <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n   <= rst_m_r;
		end
	end

	// Pin inputs: bit 1 brown-out, bit 0 master clear (low active)
	rcc_sync #(
		.W       (2),
		.RST_VAL (2'h1)
	) u_pins (
		.clk  (REF_CLK),
		.rst_n(rst_n),
		.din  ({BROWNOUT_DETECT, MASTER_CLEAR_PIN_N}),
		.dout (pins)
	);

	// Unmapped reads return zero
	wire [15:0] rd_word = rcc_hit(rd_addr) ? (st_r & RCC_IMPL_MASK)
		: 16'h0000;

	// Register bus front end
	rcc_axil u_bus (
		.clk    (REF_CLK),
		.rst_n  (rst_n),
		.awaddr (AWADDR),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.wdata  (WDATA),
		.wstrb  (WSTRB),
		.wvalid (WVALID),
		.wready (WREADY),
		.bresp  (BRESP),
		.bvalid (BVALID),
		.bready (BREADY),
		.araddr (ARADDR),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.rdata  (RDATA),
		.rresp  (RRESP),
		.rvalid (RVALID),
		.rready (RREADY),
		.wr_en  (wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok  (rcc_hit(wr_addr)),
		.rd_en  (rd_en),
		.rd_addr(rd_addr),
		.rd_data({16'h0000, rd_word}),
		.rd_ok  (rcc_hit(rd_addr))
	);

	// Reset sources and cause events
	wire ev_bor   = pins[1];
	wire ev_master_clear_pin  = !pins[0];
	wire ev_ill   = ILLEGAL_OPCODE | ILLEGAL_ADDR_MODE
		| UNINIT_WREG_POINTER;
	wire any_src  = ev_bor | ev_master_clear_pin | INSTR_RESET_REQ
		| WATCHDOG_TIMEOUT | CONFIG_MISMATCH
		| TRAP_CONFLICT | ev_ill;
	wire sw_wr    = wr_en && rcc_hit(wr_addr);
	wire [15:0] wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

	// Hardware set bits, one per cause
	wire [15:0] set_v = ({15'h0000, 1'b0}
		| (16'h0001 << RCC_B_TRAP)     & {16{TRAP_CONFLICT}}
		| (16'h0001 << RCC_B_ILLEGAL)  & {16{ev_ill}}
		| (16'h0001 << RCC_B_CFGMIS)   & {16{CONFIG_MISMATCH}}
		| (16'h0001 << RCC_B_EXTPIN)   & {16{ev_master_clear_pin}}
		| (16'h0001 << RCC_B_INSTR)    & {16{INSTR_RESET_REQ}}
		| (16'h0001 << RCC_B_WATCHDOG_TIMEOUT_FLAG)     & {16{WATCHDOG_TIMEOUT}}
		| (16'h0001 << RCC_B_SLEEP)    & {16{SLEEP_ENTERED}}
		| (16'h0001 << RCC_B_IDLE)     & {16{IDLE_ENTERED}}
		| (16'h0001 << RCC_B_BROWNOUT) & {16{ev_bor}});

	// Software write merged with hardware sets; set wins
	assign st_nxt = (((sw_wr ? ((st_r & ~wmask)
		| (wr_data[15:0] & wmask)) : st_r))
		| set_v) & RCC_IMPL_MASK;

	// Status word; only power-on reset clears it
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= RCC_POR_VAL;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Master reset and oscillator load on every reset
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			sys_rst_r <= 1'b1;
			osc_r     <= RCC_OSC_RST;
		end else begin
			sys_rst_r <= any_src;
			if (sys_rst_r) begin
				osc_r <= STARTUP_OSCILLATOR_SELECT;
			end
		end
	end

	// Outputs
	assign MASTER_SYSTEM_RESET          = sys_rst_r;
	assign NEW_OSCILLATOR_FIELD         = osc_r;
	assign WATCHDOG_RUN                 = st_r[RCC_B_WDT_EN]
		| (WATCHDOG_CONFIG_FIELD == RCC_WDT_CFG_ON);
	assign FLASH_REGULATOR_SLEEP_ACTIVE = st_r[RCC_B_FLASH_REG];
	assign MAIN_REGULATOR_SLEEP_ACTIVE  = st_r[RCC_B_MAIN_REG];

	// Checks on the logic above
	AST_MERGE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		$past(rst_n) |-> MASTER_SYSTEM_RESET == $past(any_src))
		else $error("master reset does not follow sources");
	AST_SRC_RESET: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		$rose(ev_master_clear_pin) |=> MASTER_SYSTEM_RESET [*1] ##1 1'b1)
		else $error("pin reset did not assert master reset");
	AST_CAUSE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		any_src |=> (st_r & $past(set_v)) == $past(set_v))
		else $error("reset cause flag not set");
	AST_POR_VAL: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		$rose(rst_n) |-> st_r == RCC_POR_VAL)
		else $error("power-on status value wrong");
	AST_SW_WRITE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		(sw_wr && wr_strb[1:0] == 2'h3 && set_v == 16'h0000
		&& !any_src)
		|=> st_r == ($past(wr_data[15:0]) & RCC_IMPL_MASK)
		&& !MASTER_SYSTEM_RESET)
		else $error("software write not stored or caused reset");
	AST_OSC_LOAD: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		sys_rst_r |=> NEW_OSCILLATOR_FIELD
		== $past(STARTUP_OSCILLATOR_SELECT))
		else $error("oscillator selection not loaded");
	AST_TRAP: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		TRAP_CONFLICT |=> st_r[RCC_B_TRAP] && MASTER_SYSTEM_RESET)
		else $error("trap flag not set");
	AST_ILLEGAL: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		(ILLEGAL_OPCODE || ILLEGAL_ADDR_MODE || UNINIT_WREG_POINTER)
		|=> st_r[RCC_B_ILLEGAL])
		else $error("illegal condition flag not set");
	AST_FLASH_REG: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		$rose(RVALID) && RRESP == RCC_RESP_OKAY
		|-> RDATA[RCC_B_FLASH_REG] == $past(FLASH_REGULATOR_SLEEP_ACTIVE))
		else $error("flash regulator control mismatch");
	AST_CFGMIS: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		CONFIG_MISMATCH |=> st_r[RCC_B_CFGMIS])
		else $error("mismatch flag not set");
	AST_MAIN_REG: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		$changed(MAIN_REGULATOR_SLEEP_ACTIVE) |-> $past(sw_wr))
		else $error("main regulator control changed without write");
	AST_PIN: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		ev_master_clear_pin |=> st_r[RCC_B_EXTPIN])
		else $error("pin reset flag not set");
	AST_INSTR: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		INSTR_RESET_REQ |=> st_r[RCC_B_INSTR])
		else $error("instruction reset flag not set");
	AST_WDT_RUN: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		WATCHDOG_CONFIG_FIELD == RCC_WDT_CFG_ON |-> WATCHDOG_RUN)
		else $error("watchdog not forced on");
	AST_WATCHDOG_TIMEOUT_FLAG: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		WATCHDOG_TIMEOUT |=> st_r[RCC_B_WATCHDOG_TIMEOUT_FLAG] ##1 1'b1)
		else $error("watchdog flag not set");
	AST_WAKE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		SLEEP_ENTERED || IDLE_ENTERED
		|=> (!$past(SLEEP_ENTERED) || st_r[RCC_B_SLEEP])
		&& (!$past(IDLE_ENTERED) || st_r[RCC_B_IDLE]))
		else $error("wake flag not set");
	AST_BOR: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		ev_bor |=> st_r[RCC_B_BROWNOUT])
		else $error("brown-out flag not set");
	AST_ZERO: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		RVALID |-> (RDATA[15:0] & ~RCC_IMPL_MASK) == 16'h0000)
		else $error("unimplemented bits read nonzero");
	AST_STICKY: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		!$past(sw_wr) |-> ($past(st_r) & ~st_r) == 16'h0000)
		else $error("flag cleared without software");

	// Idle flag, release, holds, bus answers and byte lanes
	AST_IDLE: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		IDLE_ENTERED |=> st_r[RCC_B_IDLE])
		else $error("idle wake flag not set");
	AST_RELEASE: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		!any_src |=> !MASTER_SYSTEM_RESET)
		else $error("master reset held without a source");
	AST_OSC_KEEP: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		!sys_rst_r |=> $stable(NEW_OSCILLATOR_FIELD))
		else $error("oscillator field changed outside reset");
	AST_WR_ANSWER: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		wr_en && rcc_hit(wr_addr) |=> BVALID && BRESP == RCC_RESP_OKAY)
		else $error("status write not answered okay");
	AST_UNMAP_WR: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		wr_en && !rcc_hit(wr_addr) && set_v == 16'h0000
		|=> BRESP == RCC_RESP_SLVERR && $stable(st_r))
		else $error("unmapped write answered or stored");
	AST_UNMAP_RD: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		$rose(RVALID) && RRESP == RCC_RESP_SLVERR |-> RDATA == 32'h0000_0000)
		else $error("unmapped read data nonzero");
	AST_UPPER: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		RVALID |-> RDATA[31:16] == 16'h0000)
		else $error("upper read half nonzero");
	AST_ST_ZERO: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		(st_r & ~RCC_IMPL_MASK) == 16'h0000)
		else $error("unimplemented status bit held");
	AST_FREG_HOLD: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		$changed(FLASH_REGULATOR_SLEEP_ACTIVE) |-> $past(sw_wr))
		else $error("flash regulator control changed without write");
	AST_WDT_SOFT: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		WATCHDOG_CONFIG_FIELD != RCC_WDT_CFG_ON
		|-> WATCHDOG_RUN == st_r[RCC_B_WDT_EN])
		else $error("watchdog run not following enable bit");
	AST_LANE: assert property (
		@(posedge REF_CLK) disable iff (!rst_n)
		sw_wr && wr_strb[1:0] == 2'h1 && set_v == 16'h0000
		|=> $stable(st_r[15:8]))
		else $error("high byte written without its strobe");
endmodule

// [testbench/rcc_partner.sv]
// Core-side model that receives the master system reset.
// Assumes the reset is an active-high level on the bench clock.
`timescale 1ns/10ps
module rcc_partner (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	output logic      [7:0] rel_cnt,
	input  wire logic [2:0] osc,
	output logic      [2:0] clk_sel
);
	logic sys_rst_q;

	// Core starts out held in reset
	initial begin
		rel_cnt = 8'h00;
		clk_sel = 3'h0;
		sys_rst_q = 1'b1;
	end

	// Count releases, take clock choice as reset drops
	always @(posedge clk) begin
		sys_rst_q <= sys_rst;
		if (sys_rst_q && !sys_rst) begin
			rel_cnt <= rel_cnt + 8'h01;
			clk_sel <= osc;
		end
	end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the reset cause controller.
// Assumes the status word sits alone at byte offset 0x00.
`timescale 1ns/10ps
module tb_top;
	import rcc_pkg::*;

	// Source rows: sources {master_clear_pin,bor,idle,sleep,..,instr}, flags
	localparam logic [26:0] ROWS [11] = '{
		{11'h001, 16'h0040},
		{11'h002, 16'h0010},
		{11'h004, 16'h0200},
		{11'h008, 16'h8000},
		{11'h010, 16'h4000},
		{11'h020, 16'h4000},
		{11'h040, 16'h4000},
		{11'h080, 16'h0008},
		{11'h100, 16'h0004},
		{11'h200, 16'h0002},
		{11'h400, 16'h0080}
	};

	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [10:0] src = '0;
	logic [1:0]  wcfg = 2'h0;
	logic [2:0]  osc_sel = 3'h5;
	logic [7:0]  awaddr = '0;
	logic [7:0]  araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = '0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        msr, wrun, freg, mreg;
	logic [1:0]  bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic [2:0]  nosc, csel;
	logic [7:0]  rel, r0;
	int          n_fail = 0;
	int          n_tests = 0;
	int          cyc = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	rcc_top u_dut (
		.REF_CLK(clk), .RSTN(rstn), .MASTER_CLEAR_PIN_N(~src[10]),
		.BROWNOUT_DETECT(src[9]), .INSTR_RESET_REQ(src[0]),
		.WATCHDOG_TIMEOUT(src[1]), .CONFIG_MISMATCH(src[2]),
		.TRAP_CONFLICT(src[3]), .ILLEGAL_OPCODE(src[4]),
		.ILLEGAL_ADDR_MODE(src[5]), .UNINIT_WREG_POINTER(src[6]),
		.SLEEP_ENTERED(src[7]), .IDLE_ENTERED(src[8]),
		.WATCHDOG_CONFIG_FIELD(wcfg), .STARTUP_OSCILLATOR_SELECT(osc_sel),
		.MASTER_SYSTEM_RESET(msr), .NEW_OSCILLATOR_FIELD(nosc),
		.WATCHDOG_RUN(wrun), .FLASH_REGULATOR_SLEEP_ACTIVE(freg),
		.MAIN_REGULATOR_SLEEP_ACTIVE(mreg), .AWADDR(awaddr),
		.AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
		.WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(rready)
	);

	rcc_partner u_core (
		.clk(clk), .sys_rst(msr), .rel_cnt(rel), .osc(nosc), .clk_sel(csel)
	);

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task done(input string s);
		$display("END %s", s);
	endtask

	task finish_test;
		$display("checks %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Write: offer address and data, release each when taken
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	// Read: hold address until taken, data until answered
	task axr(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	// Hold sources for eight cycles, then let the reset run out
	task fire(input logic [10:0] s, input logic [2:0] o);
		@(posedge clk);
		osc_sel <= o;
		src <= s;
		r0 = rel;
		repeat (8) @(posedge clk);
		src <= '0;
		repeat (14) @(posedge clk);
	endtask

	task por;
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			finish_test();
		end
	end

	// Main sequence
	initial begin
		por();
		chk(csel, 3'h5);
		axr(RCC_STATUS_OFS);
		chk(rd, 32'h0000_0003);
		chk({mreg, freg}, 2'b00);
		axw(RCC_STATUS_OFS, 32'h0, 4'hF);
		chk(rsp, RCC_RESP_OKAY);
		done("power-on");
		for (int i = 0; i < 11; i++) begin
			fire(ROWS[i][26:16], i[2:0]);
			chk(rel - r0, {31'h0, ROWS[i][3:2] == 2'b00});
			if (ROWS[i][3:2] == 2'b00) chk(csel, i[2:0]);
			axr(RCC_STATUS_OFS);
			chk(rd, {16'h0, ROWS[i][15:0]});
			axw(RCC_STATUS_OFS, 32'h0, 4'hF);
		end
		done("causes");
		fire(11'h001, 3'h2);
		fire(11'h002, 3'h3);
		axr(RCC_STATUS_OFS);
		chk(rd, 32'h0000_0050);
		chk(csel, 3'h3);
		r0 = rel;
		axw(RCC_STATUS_OFS, 32'hFFFF_FFFF, 4'hF);
		repeat (10) @(posedge clk);
		chk(rel - r0, 32'h0);
		axr(RCC_STATUS_OFS);
		chk(rd, 32'h0000_CBFF);
		chk({mreg, freg, wrun}, 3'b111);
		axw(RCC_STATUS_OFS, 32'h0, 4'h1);
		axr(RCC_STATUS_OFS);
		chk(rd, 32'h0000_CB00);
		axw(8'h04, 32'h0, 4'hF);
		chk(rsp, RCC_RESP_SLVERR);
		axr(8'h04);
		chk(rd, 32'h0);
		chk(rsp, RCC_RESP_SLVERR);
		axr(RCC_STATUS_OFS);
		chk(rd, 32'h0000_CB00);
		done("unmapped");
		axw(RCC_STATUS_OFS, 32'h0, 4'hF);
		repeat (2) @(posedge clk);
		chk({mreg, freg, wrun}, 3'b000);
		wcfg <= RCC_WDT_CFG_ON;
		repeat (2) @(posedge clk);
		chk(wrun, 1'b1);
		done("software");
		fire(11'h008, 3'h1);
		chk(csel, 3'h1);
		osc_sel <= 3'h6;
		por();
		axr(RCC_STATUS_OFS);
		chk(rd, 32'h0000_0003);
		chk(csel, 3'h6);
		done("second power-on");
		finish_test();
	end
endmodule
